// *** sptm_consts.svh ***
// offsets, field positions, reset values for the set point and training mode registers
`ifndef SPTM_CONSTS_SVH
`define SPTM_CONSTS_SVH
`define SPTM_ADDR_TRAIN_CTRL   6'h0d
`define SPTM_ADDR_DATA_REF     6'h0e
`define SPTM_ADDR_CAL_INVERT   6'h0f
`define SPTM_BIT_CBT           0
`define SPTM_BIT_RPT           1
`define SPTM_BIT_VRO           2
`define SPTM_BIT_FAST          3
`define SPTM_BIT_RRO           4
`define SPTM_BIT_DMD           5
`define SPTM_BIT_WRITE_SET_POINT_SELECT        6
`define SPTM_BIT_OPERATING_SET_POINT_SELECT        7
`define SPTM_BIT_RANGE         6
`define SPTM_REF_MAX           6'h32
`define SPTM_TRAIN_RESET       8'h10
`define SPTM_DREF_RESET        8'h4d
`define SPTM_INVERT_RESET      8'h55
`define SPTM_RATE_SUBST        3'h3
`define SPTM_RATE_LOW_A        3'h1
`define SPTM_RATE_LOW_B        3'h2
`endif

// *** sptm_pkg.sv ***
// types for the set point and training mode registers
package sptm_pkg;
  typedef enum logic [1:0] {
    SPTM_CMD_NONE = 2'b00,
    SPTM_CMD_MRW  = 2'b01,
    SPTM_CMD_MRR  = 2'b10
  } sptm_cmd_t;
  typedef logic [7:0] sptm_byte_t;
endpackage

// *** sptm_regs.sv ***
// set point and training mode register bank of one DRAM channel
`timescale 1ns/1ps
`include "sptm_consts.svh"

module sptm_regs
  import sptm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire sptm_cmd_t  cmd,
  input  wire logic [5:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cke,
  input  wire logic [5:0] ca_in,
  input  wire logic       feature_rro_valid,
  input  wire logic [2:0] raw_refresh_rate,
  input  wire logic       cal_readout,
  input  wire logic       cal_bit,
  input  wire logic       read_dbi_en,
  input  wire logic [7:0] ca_ref_level_op,
  output logic [7:0]      dq_out_r,
  output logic [7:0]      dq_oe_r,
  output logic            dmi_out_r,
  output logic            cmd_ignore_r,
  output logic            preamble_training_r,
  output logic            ref_out_en_r,
  output logic            ref_fast_settle_r,
  output logic            mask_disable_r,
  output logic            dbi_active_r,
  output logic [2:0]      refresh_rate_status_r,
  output logic            op_set_point_r,
  output logic [7:0]      data_ref_active_r,
  output logic            mrr_valid_r
);

  // ==========================================================================
  // storage
  // ==========================================================================
  logic [7:0] train_ctrl_r;
  logic [6:0] data_ref_r [2];
  logic [7:0] invert_r;

  logic wr_train;
  logic wr_dref;
  logic wr_inv;
  logic rd_dref;
  logic wr_sel;
  logic op_sel;
  logic cbt_mirror;

  assign wr_train = (cmd == SPTM_CMD_MRW) && (cmd_addr == `SPTM_ADDR_TRAIN_CTRL);
  assign wr_dref  = (cmd == SPTM_CMD_MRW) && (cmd_addr == `SPTM_ADDR_DATA_REF);
  assign wr_inv   = (cmd == SPTM_CMD_MRW) && (cmd_addr == `SPTM_ADDR_CAL_INVERT);
  assign rd_dref  = (cmd == SPTM_CMD_MRR) && (cmd_addr == `SPTM_ADDR_DATA_REF);
  assign wr_sel   = train_ctrl_r[`SPTM_BIT_WRITE_SET_POINT_SELECT];
  assign op_sel   = train_ctrl_r[`SPTM_BIT_OPERATING_SET_POINT_SELECT];
  assign cbt_mirror = train_ctrl_r[`SPTM_BIT_CBT] && !cke;

  // ==========================================================================
  // training control (write only, no read path)
  // ==========================================================================
  // writes are ignored while mirroring; the controller raises cke first to leave
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      train_ctrl_r <= `SPTM_TRAIN_RESET;
    end else if (wr_train && !cbt_mirror) begin
      train_ctrl_r <= cmd_wdata;
    end
  end

  // ==========================================================================
  // data reference, one copy per set point
  // ==========================================================================
  // reserved level codes are stored as written; keeping them out is the controller's job
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      data_ref_r[0] <= 7'(`SPTM_DREF_RESET);
      data_ref_r[1] <= 7'(`SPTM_DREF_RESET);
    end else if (wr_dref && !cbt_mirror) begin
      data_ref_r[wr_sel] <= cmd_wdata[6:0];
    end
  end

  // ==========================================================================
  // calibration invert mask
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      invert_r <= `SPTM_INVERT_RESET;
    end else if (wr_inv && !cbt_mirror) begin
      invert_r <= cmd_wdata;
    end
  end

  // ==========================================================================
  // mode outputs
  // ==========================================================================
  function automatic logic [2:0] rate_filter(input logic [2:0] raw, input logic opt,
                                             input logic valid);
    if (valid && !opt && (raw == `SPTM_RATE_LOW_A || raw == `SPTM_RATE_LOW_B))
      return `SPTM_RATE_SUBST;
    return raw;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd_ignore_r          <= 1'b0;
      preamble_training_r   <= 1'b0;
      ref_out_en_r          <= 1'b0;
      ref_fast_settle_r     <= 1'b0;
      mask_disable_r        <= 1'b0;
      op_set_point_r        <= 1'b0;
      refresh_rate_status_r <= 3'h0;
      data_ref_active_r     <= 8'h0;
      dbi_active_r          <= 1'b0;
    end else begin
      cmd_ignore_r          <= cbt_mirror;
      preamble_training_r   <= train_ctrl_r[`SPTM_BIT_RPT];
      ref_out_en_r          <= train_ctrl_r[`SPTM_BIT_VRO];
      ref_fast_settle_r     <= train_ctrl_r[`SPTM_BIT_FAST];
      mask_disable_r        <= train_ctrl_r[`SPTM_BIT_DMD];
      op_set_point_r        <= op_sel;
      refresh_rate_status_r <= rate_filter(raw_refresh_rate, train_ctrl_r[`SPTM_BIT_RRO],
                                           feature_rro_valid);
      data_ref_active_r     <= {1'b0, data_ref_r[op_sel]};
      dbi_active_r          <= read_dbi_en && !cal_readout;
    end
  end

  // ==========================================================================
  // DQ drive: mirror, reference output, calibration, register read
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dq_out_r    <= 8'h0;
      dq_oe_r     <= 8'h0;
      dmi_out_r   <= 1'b0;
      mrr_valid_r <= 1'b0;
    end else begin
      mrr_valid_r <= 1'b0;
      dmi_out_r   <= 1'b0;
      if (cbt_mirror) begin
        dq_out_r <= {2'b00, ca_in};
        dq_oe_r  <= 8'h3f;
      end else if (train_ctrl_r[`SPTM_BIT_VRO]) begin
        // bit 0 of each level code stands for the analog voltage: CA level on DQ0, data level on DQ1
        dq_out_r <= {6'h0, data_ref_r[op_sel][0], ca_ref_level_op[0]};
        dq_oe_r  <= 8'h03;
      end else if (cal_readout) begin
        dq_out_r  <= {8{cal_bit}} ^ invert_r;
        dq_oe_r   <= 8'hff;
        dmi_out_r <= cal_bit;
      end else if (rd_dref) begin
        dq_out_r    <= {1'b0, data_ref_r[wr_sel]};
        dq_oe_r     <= 8'hff;
        mrr_valid_r <= 1'b1;
      end else begin
        dq_out_r <= 8'h0;
        dq_oe_r  <= 8'h0;
      end
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  cbt_mirror_a: assert property (
    train_ctrl_r[`SPTM_BIT_CBT] && !cke
    |=> dq_out_r[5:0] == $past(ca_in) && cmd_ignore_r)
    else $error("training mirror wrong");

  mirror_oe_a: assert property (
    cbt_mirror
    |=> dq_oe_r == 8'h3f && dq_out_r[7:6] == 2'b00)
    else $error("mirror drive enables wrong");

  mirror_hold_a: assert property (
    cbt_mirror && wr_dref
    |=> data_ref_r[0] == $past(data_ref_r[0]) && data_ref_r[1] == $past(data_ref_r[1]))
    else $error("command taken during mirror");

  mirror_quiet_a: assert property (
    cbt_mirror
    |=> !mrr_valid_r)
    else $error("read answered during mirror");

  train_write_a: assert property (
    wr_train && !cbt_mirror
    |=> train_ctrl_r == $past(cmd_wdata))
    else $error("training write lost");

  preamble_out_a: assert property (
    1'b1
    |=> preamble_training_r == $past(train_ctrl_r[`SPTM_BIT_RPT]))
    else $error("preamble training output lags");

  ref_out_en_a: assert property (
    1'b1
    |=> ref_out_en_r == $past(train_ctrl_r[`SPTM_BIT_VRO]))
    else $error("reference output flag lags");

  ref_drive_a: assert property (
    train_ctrl_r[`SPTM_BIT_VRO] && !cbt_mirror
    |=> dq_oe_r == 8'h03 && dq_out_r[0] == $past(ca_ref_level_op[0])
        && dq_out_r[1] == $past(data_ref_r[op_sel][0]))
    else $error("reference levels not driven");

  fast_settle_a: assert property (
    1'b1
    |=> ref_fast_settle_r == $past(train_ctrl_r[`SPTM_BIT_FAST]))
    else $error("fast settle output lags");

  rate_subst_a: assert property (
    feature_rro_valid && !train_ctrl_r[`SPTM_BIT_RRO]
      && raw_refresh_rate inside {`SPTM_RATE_LOW_A, `SPTM_RATE_LOW_B}
    |=> refresh_rate_status_r == `SPTM_RATE_SUBST)
    else $error("rate code not substituted");

  rate_never_a: assert property (
    feature_rro_valid && !train_ctrl_r[`SPTM_BIT_RRO]
    |=> !(refresh_rate_status_r inside {`SPTM_RATE_LOW_A, `SPTM_RATE_LOW_B}))
    else $error("disabled rate code reported");

  rate_keep_a: assert property (
    feature_rro_valid && train_ctrl_r[`SPTM_BIT_RRO]
    |=> refresh_rate_status_r == $past(raw_refresh_rate))
    else $error("rate filtered with option set");

  rate_pass_a: assert property (
    !feature_rro_valid
    |=> refresh_rate_status_r == $past(raw_refresh_rate))
    else $error("rate filtered without feature");

  mask_off_a: assert property (
    1'b1
    |=> mask_disable_r == $past(train_ctrl_r[`SPTM_BIT_DMD]))
    else $error("mask disable output lags");

  op_point_a: assert property (
    1'b1
    |=> op_set_point_r == $past(op_sel))
    else $error("operating set point lags");

  mrr_read_a: assert property (
    rd_dref && !cbt_mirror && !train_ctrl_r[`SPTM_BIT_VRO] && !cal_readout
    |=> mrr_valid_r && dq_oe_r == 8'hff && dq_out_r[7] == 1'b0
        && dq_out_r[6:0] == $past(data_ref_r[wr_sel]))
    else $error("reference readback wrong");

  mrr_quiet_a: assert property (
    !rd_dref
    |=> !mrr_valid_r)
    else $error("read answer without a read");

  fsp_write_a: assert property (
    wr_dref && !cbt_mirror
    |=> data_ref_r[$past(wr_sel)] == $past(cmd_wdata[6:0]))
    else $error("wrong set point copy written");

  inactive_keep_a: assert property (
    wr_dref && !cbt_mirror
    |=> data_ref_r[!$past(wr_sel)] == $past(data_ref_r[!wr_sel]))
    else $error("inactive copy disturbed");

  active_ref_a: assert property (
    1'b1
    |=> data_ref_active_r == {1'b0, $past(data_ref_r[op_sel])})
    else $error("active reference from wrong copy");

  range_hold_a: assert property (
    !wr_dref
    |=> data_ref_r[0] == $past(data_ref_r[0]) && data_ref_r[1] == $past(data_ref_r[1]))
    else $error("reference changed without a write");

  invert_write_a: assert property (
    wr_inv && !cbt_mirror
    |=> invert_r == $past(cmd_wdata))
    else $error("invert mask write lost");

  invert_hold_a: assert property (
    !wr_inv
    |=> invert_r == $past(invert_r))
    else $error("invert mask changed without a write");

  cal_invert_a: assert property (
    cal_readout && !cbt_mirror && !train_ctrl_r[`SPTM_BIT_VRO]
    |=> dq_out_r == ({8{$past(cal_bit)}} ^ $past(invert_r)) && dmi_out_r == $past(cal_bit))
    else $error("calibration pattern wrong");

  dmi_quiet_a: assert property (
    !cal_readout
    |=> !dmi_out_r)
    else $error("mask line driven outside calibration");

  dbi_off_a: assert property (
    cal_readout
    |=> !dbi_active_r)
    else $error("bus inversion during calibration");

  dbi_follow_a: assert property (
    !cal_readout
    |=> dbi_active_r == $past(read_dbi_en))
    else $error("bus inversion flag lags");

  cal_drive_a: assert property (
    cal_readout && !cbt_mirror && !train_ctrl_r[`SPTM_BIT_VRO]
    |=> dq_oe_r == 8'hff)
    else $error("calibration lanes not driven");

  idle_release_a: assert property (
    !cbt_mirror && !train_ctrl_r[`SPTM_BIT_VRO] && !cal_readout && !rd_dref
    |=> dq_oe_r == 8'h00 && dq_out_r == 8'h00)
    else $error("data lanes driven while idle");

  mode_out_a: assert property (
    1'b1
    |=> preamble_training_r == $past(train_ctrl_r[1]) && mask_disable_r == $past(train_ctrl_r[5]))
    else $error("mode output lags");

  cbt_c:  cover property (cbt_mirror ##1 cke ##1 wr_train);
  fsp_c:  cover property (wr_dref && wr_sel ##1 rd_dref);
  cal_c:  cover property (cal_readout [*3]);
  rate_c: cover property (feature_rro_valid && !train_ctrl_r[4] && raw_refresh_rate == 3'h1);
  vro_c:  cover property (train_ctrl_r[`SPTM_BIT_VRO] && !cbt_mirror);

endmodule // sptm_regs

// *** sptm_ctl_model.sv ***
// memory controller model issuing mode register writes and reads
`timescale 1ns/1ps
`include "sptm_consts.svh"

module sptm_ctl_model
  import sptm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] dq_out_r,
  input  wire logic       mrr_valid_r,
  output sptm_cmd_t       cmd,
  output logic [5:0]      cmd_addr,
  output logic [7:0]      cmd_wdata
);
  initial begin
    cmd = SPTM_CMD_NONE;
    cmd_addr = 6'h3f;
    cmd_wdata = 8'h00;
  end
  // ==========================================================
  // command driver
  // released address and data lines go to the inverse, cmd to none, so stale values never match
  task automatic issue(input sptm_cmd_t c, input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cmd = c;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge sys_clk);
    cmd = SPTM_CMD_NONE;
    cmd_addr = ~a;
    cmd_wdata = ~d;
  endtask
  // level and range always travel together; reserved level codes are withheld
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    if (a != `SPTM_ADDR_DATA_REF || d[5:0] <= `SPTM_REF_MAX) issue(SPTM_CMD_MRW, a, d);
  endtask
  task automatic mrr(input logic [5:0] a, output logic [7:0] d, output logic v);
    issue(SPTM_CMD_MRR, a, 8'h00);
    // answer stands for the one cycle after the taking edge, i.e. now
    d = dq_out_r;
    v = mrr_valid_r;
  endtask
endmodule // sptm_ctl_model

// *** sptm_regs_tb.sv ***
// self-checking bench for the set point and training mode registers
`timescale 1ns/1ps
`include "sptm_consts.svh"

module sptm_regs_tb;
  logic                sys_clk, reset_n, cke, cal_readout, cal_bit, read_dbi_en;
  logic                feature_rro_valid, vld;
  logic [5:0]          ca_in, cmd_addr;
  logic [2:0]          raw_refresh_rate, refresh_rate_status_r;
  logic [7:0]          cmd_wdata, ca_ref_level_op, dq_out_r, dq_oe_r, data_ref_active_r, rd;
  logic                dmi_out_r, cmd_ignore_r, preamble_training_r, ref_out_en_r;
  logic                ref_fast_settle_r, mask_disable_r, dbi_active_r, op_set_point_r;
  logic                mrr_valid_r;
  sptm_pkg::sptm_cmd_t cmd;
  int                  miscompares, n_tests, cycles;

  sptm_regs sptm_regs_i (.sys_clk, .reset_n, .cmd, .cmd_addr, .cmd_wdata, .cke, .ca_in,
    .feature_rro_valid, .raw_refresh_rate, .cal_readout, .cal_bit, .read_dbi_en,
    .ca_ref_level_op, .dq_out_r, .dq_oe_r, .dmi_out_r, .cmd_ignore_r, .preamble_training_r,
    .ref_out_en_r, .ref_fast_settle_r, .mask_disable_r, .dbi_active_r,
    .refresh_rate_status_r, .op_set_point_r, .data_ref_active_r, .mrr_valid_r);
  sptm_ctl_model sptm_ctl_model_i (.sys_clk, .dq_out_r, .mrr_valid_r, .cmd, .cmd_addr,
    .cmd_wdata);

  // ==========================================================
  // clock, timeout and shared helpers
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_modes;
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h2e);
    cyc(2);
    chk(8'({preamble_training_r, ref_out_en_r, ref_fast_settle_r, mask_disable_r}), 8'h0f);
    feature_rro_valid = 1'b1;
    raw_refresh_rate = `SPTM_RATE_LOW_A;
    cyc(2);
    chk(8'(refresh_rate_status_r), 8'(`SPTM_RATE_SUBST));
    raw_refresh_rate = `SPTM_RATE_LOW_B;
    cyc(2);
    chk(8'(refresh_rate_status_r), 8'(`SPTM_RATE_SUBST));
    feature_rro_valid = 1'b0;
    cyc(2);
    chk(8'(refresh_rate_status_r), 8'(`SPTM_RATE_LOW_B));
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h00);
  endtask
  task automatic t_setpt;
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h40);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_DATA_REF, 8'h52);
    sptm_ctl_model_i.mrr(`SPTM_ADDR_DATA_REF, rd, vld);
    chk(rd, 8'h52);
    chk(8'(vld), 8'h01);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'hc0);
    cyc(2);
    chk(8'(op_set_point_r), 8'h01);
    chk(data_ref_active_r, 8'h52);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h80);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_DATA_REF, 8'hb2);
    cyc(2);
    chk(data_ref_active_r, 8'h52);
    sptm_ctl_model_i.mrr(`SPTM_ADDR_DATA_REF, rd, vld);
    chk(rd, 8'h32);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h00);
  endtask
  task automatic t_mirror;
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h01);
    cke = 1'b0;
    ca_in = 6'h2a;
    cyc(2);
    chk(dq_out_r, 8'h2a);
    chk(dq_oe_r, 8'h3f);
    chk(8'(cmd_ignore_r), 8'h01);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_DATA_REF, 8'h11);
    cke = 1'b1;
    sptm_ctl_model_i.mrw(`SPTM_ADDR_TRAIN_CTRL, 8'h00);
    cyc(2);
    chk(8'(cmd_ignore_r), 8'h00);
    sptm_ctl_model_i.mrr(`SPTM_ADDR_DATA_REF, rd, vld);
    chk(rd, 8'h32);
  endtask
  task automatic t_cal;
    cal_readout = 1'b1;
    cal_bit = 1'b1;
    read_dbi_en = 1'b1;
    cyc(2);
    chk(dq_out_r, ~`SPTM_INVERT_RESET);
    chk(8'({dmi_out_r, dbi_active_r}), 8'h02);
    sptm_ctl_model_i.mrw(`SPTM_ADDR_CAL_INVERT, 8'h0f);
    cal_bit = 1'b0;
    cyc(2);
    chk(dq_out_r, 8'h0f);
    chk(8'(dmi_out_r), 8'h00);
    cal_readout = 1'b0;
  endtask

  initial begin
    {reset_n, cke, cal_readout, cal_bit, read_dbi_en, feature_rro_valid} = 6'h10;
    ca_in = 6'h00;
    raw_refresh_rate = 3'h0;
    ca_ref_level_op = 8'h01;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    cyc(2);
    chk(data_ref_active_r, `SPTM_DREF_RESET);
    chk(8'({preamble_training_r, ref_out_en_r, mask_disable_r, op_set_point_r}), 8'h00);
    t_modes();
    t_setpt();
    t_mirror();
    t_cal();
    test_done();
  end
endmodule // sptm_regs_tb
